// ===== hw/mcp_pkg.sv
// Package for the three-channel PWM output block.
// Assumes a classic Wishbone slave with byte-wide registers in the low data lane.
package mcp_pkg;
  // Register indices (word offsets in the device map), byte address = 4 * index
  localparam logic [25:0] MCP_IDX_CH2_DUTY = 26'h1FF80C4;
  localparam logic [25:0] MCP_IDX_CH2_SEL  = 26'h1FF80C5;
  localparam logic [25:0] MCP_IDX_CH3_DUTY = 26'h1FF80C6;
  localparam logic [25:0] MCP_IDX_CH3_SEL  = 26'h1FF80C7;
  localparam logic [25:0] MCP_IDX_CH4_DUTY = 26'h1FF80C8;
  localparam logic [25:0] MCP_IDX_CH4_SEL  = 26'h1FF80C9;
  localparam logic [25:0] MCP_IDX_PINCFG   = 26'h1FF80CA;
  localparam int          MCP_ADDR_W       = 28;
  localparam int          MCP_IDX_LSB      = 2;
  // Fields of the upper control byte (bit 15 -> 7, bit 8 -> 0)
  localparam int          MCP_SEL_BIT      = 7;
  localparam int          MCP_DIV_BIT      = 0;
  // Fields of the pin-config register
  localparam int          MCP_CFG_FLASH9   = 0;
  localparam int          MCP_CFG_GPIO4    = 1;
  localparam int          MCP_CFG_GPIO7    = 2;
  localparam logic [7:0]  MCP_DUTY_RST     = 8'h00;
  localparam logic [7:0]  MCP_SEL_RST      = 8'h00;
  localparam logic [7:0]  MCP_CFG_RST      = 8'h00;
  localparam int          MCP_PERIOD       = 256;
  localparam int          MCP_CHANNELS     = 3;
  // Pin source choices
  typedef enum logic [1:0] {MCP_SRC_BASE, MCP_SRC_ALT, MCP_SRC_PWM} mcp_src_type;
endpackage

// ===== hw/mcp_channel.sv
// One PWM channel: divider, 8-bit counter, duty compare.
// Assumes duty and divider come from registers on the same clock.
`timescale 1ns/1ps
module mcp_channel
  import mcp_pkg::*;
#(
  parameter int CNT_W = 8
)(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [CNT_W-1:0] duty_i,
  input  wire logic             div_i,
  output logic                  pwm_o,
  output logic                  wrap_o
);
  // Counter width must give exactly one period of steps
  if (CNT_W < 1 || (1 << CNT_W) != MCP_PERIOD)
  begin : g_bad_width
    $error("CNT_W must match the period");
  end

  logic             tick_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] duty_reg;
  logic             pwm_reg;
  wire logic        step = !div_i || tick_reg;                     // [R4]
  wire logic        wrap = step && (cnt_reg == {CNT_W{1'b1}});     // [R5]
  wire logic [CNT_W-1:0] cnt_next  = wrap ? '0 : cnt_reg + 1'b1;
  wire logic [CNT_W-1:0] duty_next = wrap ? duty_i : duty_reg;     // [R9]
  wire logic        pwm_next = (cnt_next <= duty_next);           // [R6] [R7] [R8]

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tick_reg <= 1'b0;
      cnt_reg  <= '0;
      duty_reg <= '0;
      pwm_reg  <= 1'b1;
    end
    else
    begin
      tick_reg <= div_i ? !tick_reg : 1'b0;                        // [R4]
      if (step)
      begin
        cnt_reg  <= cnt_next;                                      // [R9]
        duty_reg <= duty_next;
        pwm_reg  <= pwm_next;
      end
    end
  end

  assign pwm_o  = pwm_reg;
  assign wrap_o = wrap;

  // Divided step followed by a cycle still in divide mode
  sequence s_div_step;
    (div_i && step) ##1 div_i;
  endsequence

  a_high_len: assert property (@(posedge clk_i) disable iff (rst_i)  // [R6]
    step |=> (pwm_o == (cnt_reg <= duty_reg)))
    else $error("pwm level disagrees with count and duty");
  a_duty_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    !$past(wrap) && !$past(rst_i) |-> $stable(duty_reg))
    else $error("duty changed inside a period");
  a_div_rate: assert property (@(posedge clk_i) disable iff (rst_i)  // [R4]
    s_div_step |-> !step)
    else $error("divided clock stepped twice in a row");
  a_cnt_step: assert property (@(posedge clk_i) disable iff (rst_i)  // [R8]
    step && !wrap |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("counter did not advance");
  a_wrap_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    wrap |=> cnt_reg == '0)
    else $error("period did not restart at zero");
endmodule

// ===== hw/mcp_top.sv
// Three PWM channels (2..4) with shared-pin muxing, classic Wishbone slave.
// Assumes the pin alternates arrive from same-clock logic; gpio inputs from pins.
//
// How it works
// [R1] Ch2 pin: flash select, NAND select, or PWM
// [R2] Ch3 pin: gpio five, chip select three, or PWM
// [R3] Ch4 pin: gpio ten, modem port line, or PWM
// [R4] Channel clock is auxiliary clock over divider plus one
// [R5] Period spans 256 divided channel clocks
// [R6] High for duty plus one of 256
// [R7] Low for the remaining steps
// [R8] Duty resolution from an 8-bit counter
// [R9] Free counter; new duty loads at boundary
`timescale 1ns/1ps
module mcp_top
  import mcp_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [MCP_ADDR_W-1:0] adr_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  input  wire logic                  flash_select_one_n_i,
  input  wire logic                  nand_select_one_n_i,
  input  wire logic                  chip_select_three_n_i,
  input  wire logic                  modem_core_port_line_i,
  input  wire logic                  gpio5_out_i,
  input  wire logic                  gpio5_oe_i,
  input  wire logic                  gpio10_out_i,
  input  wire logic                  gpio10_oe_i,
  input  wire logic                  pin_two_i,
  input  wire logic                  pin_three_i,
  input  wire logic                  pin_four_i,
  output logic                       gpio5_in_o,
  output logic                       gpio10_in_o,
  output logic                       pin_two_o,
  output logic                       pin_two_oe_o,
  output logic                       pin_three_o,
  output logic                       pin_three_oe_o,
  output logic                       pin_four_o,
  output logic                       pin_four_oe_o,
  output logic                       waveform_out_two_o,
  output logic                       waveform_out_three_o,
  output logic                       waveform_out_four_o
);
  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0] duty_reg [MCP_CHANNELS];
  logic [7:0] ctl_reg  [MCP_CHANNELS];
  logic [7:0] cfg_reg;
  logic       ack_reg;
  logic [7:0] rdata_reg;
  logic [2:0] pwm;

  wire logic [25:0] idx    = adr_i[MCP_ADDR_W-1:MCP_IDX_LSB];
  wire logic        req    = cyc_i && stb_i && !ack_reg;
  wire logic        wr     = req && we_i && sel_i[0];
  wire logic [7:0]  wdata  = dat_i[7:0];
  wire logic        hit_d2 = (idx == MCP_IDX_CH2_DUTY);
  wire logic        hit_s2 = (idx == MCP_IDX_CH2_SEL);
  wire logic        hit_d3 = (idx == MCP_IDX_CH3_DUTY);
  wire logic        hit_s3 = (idx == MCP_IDX_CH3_SEL);
  wire logic        hit_d4 = (idx == MCP_IDX_CH4_DUTY);
  wire logic        hit_s4 = (idx == MCP_IDX_CH4_SEL);
  wire logic        hit_cf = (idx == MCP_IDX_PINCFG);
  wire logic [2:0]  hit_d  = {hit_d4, hit_d3, hit_d2};
  wire logic [2:0]  hit_s  = {hit_s4, hit_s3, hit_s2};
  // Unused select bits 14..9 read as zero
  wire logic [7:0]  ctl_mask = (8'h01 << MCP_SEL_BIT) | (8'h01 << MCP_DIV_BIT);
  wire logic [7:0]  cfg_mask = (8'h01 << MCP_CFG_FLASH9) | (8'h01 << MCP_CFG_GPIO4) | (8'h01 << MCP_CFG_GPIO7);
  wire logic [7:0]  rdata =
    hit_d2 ? duty_reg[0] : hit_s2 ? ctl_reg[0] :
    hit_d3 ? duty_reg[1] : hit_s3 ? ctl_reg[1] :
    hit_d4 ? duty_reg[2] : hit_s4 ? ctl_reg[2] :
    hit_cf ? cfg_reg : 8'h00;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 8'h00;
      cfg_reg   <= MCP_CFG_RST;
    end
    else
    begin
      ack_reg   <= req;
      rdata_reg <= rdata;
      if (wr && hit_cf)
        cfg_reg <= wdata & cfg_mask;
    end
  end

  // ------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------
  for (genvar c = 0; c < MCP_CHANNELS; c++)
  begin : g_ch
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        duty_reg[c] <= MCP_DUTY_RST;
        ctl_reg[c]  <= MCP_SEL_RST;
      end
      else
      begin
        if (wr && hit_d[c])
          duty_reg[c] <= wdata;
        if (wr && hit_s[c])
          ctl_reg[c] <= wdata & ctl_mask;
      end
    end
    mcp_channel #(.CNT_W(8)) u_ch (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .duty_i (duty_reg[c]),
      .div_i  (ctl_reg[c][MCP_DIV_BIT]),
      .pwm_o  (pwm[c]),
      .wrap_o ()
    );
  end

  assign ack_o = ack_reg;
  assign dat_o = {24'h000000, rdata_reg};
  assign waveform_out_two_o   = pwm[0];
  assign waveform_out_three_o = pwm[1];
  assign waveform_out_four_o  = pwm[2];

  // ------------------------------------------------------------
  // Shared pin muxing
  // ------------------------------------------------------------
  wire logic en2 = cfg_reg[MCP_CFG_FLASH9];
  wire logic en3 = cfg_reg[MCP_CFG_GPIO4];
  wire logic en4 = cfg_reg[MCP_CFG_GPIO7];
  wire logic os2 = ctl_reg[0][MCP_SEL_BIT];
  wire logic os3 = ctl_reg[1][MCP_SEL_BIT];
  wire logic os4 = ctl_reg[2][MCP_SEL_BIT];

  assign pin_two_o = !en2 ? flash_select_one_n_i :
                     !os2 ? nand_select_one_n_i : pwm[0];                  // [R1]
  assign pin_two_oe_o = 1'b1;
  assign pin_three_o  = !en3 ? gpio5_out_i : !os3 ? chip_select_three_n_i : pwm[1]; // [R2]
  assign pin_three_oe_o = !en3 ? gpio5_oe_i : 1'b1;                         // [R2]
  assign pin_four_o   = !en4 ? gpio10_out_i : !os4 ? modem_core_port_line_i : pwm[2]; // [R3]
  assign pin_four_oe_o  = !en4 ? gpio10_oe_i : 1'b1;                        // [R3]

  // Pin reads for gpio, two-stage synchronised
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
    end
    else
    begin
      s1_reg <= {pin_four_i, pin_three_i, pin_two_i};
      s2_reg <= s1_reg;
    end
  end
  assign gpio5_in_o  = s2_reg[1];
  assign gpio10_in_o = s2_reg[2];

  // One-cycle acknowledge pulse
  sequence s_ack_pulse;
    ack_o ##1 !ack_o;
  endsequence

  a_pin_two: assert property (@(posedge clk_i) disable iff (rst_i)       // [R1]
    en2 && os2 |-> pin_two_o == pwm[0])
    else $error("pin two not showing pwm");
  a_pin_two_flash: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    !en2 |-> pin_two_o == flash_select_one_n_i)
    else $error("pin two not showing flash select");
  a_pin_three: assert property (@(posedge clk_i) disable iff (rst_i)     // [R2]
    en3 && !os3 |-> pin_three_o == chip_select_three_n_i && pin_three_oe_o)
    else $error("pin three not showing chip select");
  a_pin_four: assert property (@(posedge clk_i) disable iff (rst_i)      // [R3]
    en4 |-> pin_four_o == (os4 ? pwm[2] : modem_core_port_line_i))
    else $error("pin four source wrong");
  a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> s_ack_pulse)
    else $error("ack not one cycle after request");
endmodule

// ===== sim/mcp_pin_model.sv
// Pin model: resolves the three shared pins from the block's drive.
// Assumes pull-ups on the board hold undriven pins high.
`timescale 1ns/1ps
module mcp_pin_model (
  input  wire logic [2:0] o_i,
  input  wire logic [2:0] oe_i,
  output logic      [2:0] lvl_o
);
  // Undriven pins rest at the pull-up level
  assign lvl_o = (oe_i & o_i) | ~oe_i;
endmodule

// ===== sim/tb_top.sv
// Bench for the three-channel PWM block: registers, pin muxing, waveforms.
// Assumes a classic Wishbone master and the pin model on the far side.
`timescale 1ns/1ps
module tb_top;
  import mcp_pkg::*;
  logic                  clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [3:0]            sel = 4'hF;
  logic [MCP_ADDR_W-1:0] adr = '0;
  logic [31:0]           dat = '0, dat_o, q;
  logic                  ack_o, fs = 0, ns = 0, cs = 0, md = 0;
  logic                  g5 = 0, g5e = 0, g10 = 0, g10e = 0, gi5, gi10;
  logic [2:0]            po, poe, lvl, wv;
  int                    error_cnt = 0, n_compared = 0, nh, nl;
  logic [25:0]           ridx [8] = '{26'h1FF80C4, 26'h1FF80C5, 26'h1FF80C6, 26'h1FF80C7,
                                      26'h1FF80C8, 26'h1FF80C9, 26'h1FF80CA, 26'h1FF80CB};
  logic [7:0]            rwr [8] = '{8'hA5, 8'h81, 8'h3C, 8'h01, 8'hFF, 8'h80, 8'h05, 8'hAA};
  logic [7:0]            rex [8] = '{8'hA5, 8'h81, 8'h3C, 8'h01, 8'hFF, 8'h80, 8'h05, 8'h00};
  logic [7:0]            pd [5] = '{8'h00, 8'hFE, 8'h80, 8'h7F, 8'h00};
  int                    pc [5] = '{0, 1, 2, 0, 2};
  logic                  pv [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  mcp_top DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(sel),
    .adr_i(adr), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .flash_select_one_n_i(fs), .nand_select_one_n_i(ns), .chip_select_three_n_i(cs),
    .modem_core_port_line_i(md), .gpio5_out_i(g5), .gpio5_oe_i(g5e), .gpio10_out_i(g10),
    .gpio10_oe_i(g10e), .pin_two_i(lvl[0]), .pin_three_i(lvl[1]), .pin_four_i(lvl[2]),
    .gpio5_in_o(gi5), .gpio10_in_o(gi10), .pin_two_o(po[0]), .pin_two_oe_o(poe[0]),
    .pin_three_o(po[1]), .pin_three_oe_o(poe[1]), .pin_four_o(po[2]), .pin_four_oe_o(poe[2]),
    .waveform_out_two_o(wv[0]), .waveform_out_three_o(wv[1]), .waveform_out_four_o(wv[2])
  );
  mcp_pin_model PINS (.o_i(po), .oe_i(poe), .lvl_o(lvl));
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  //----------------------------------------
  // Tasks
  //----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic wb(input logic [25:0] i, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= {i, 2'b00}; dat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) chk("ack", 1, 0);
    q = dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic edge_up(input int c);
    int   n;
    logic prev;
    logic rise;
    n = 0;
    rise = 1'b0;
    prev = wv[c];
    do
    begin
      @(posedge clk_i);
      n++;
      rise = (wv[c] === 1'b1 && prev === 1'b0);
      prev = wv[c];
    end while (!rise && n < 1100);
    if (!rise) chk("rise", 1, 0);
  endtask
  task automatic summarize;
    $display("checked %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    error_cnt++;
    summarize();
  end
  //----------------------------------------
  // Sequence
  //----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    foreach (ridx[k])
    begin
      wb(ridx[k], 0, 0);
      chk("reset value", 0, q);
    end
    foreach (ridx[k])
    begin
      wb(ridx[k], 1, rwr[k]);
      wb(ridx[k], 0, 0);
      chk("readback", {24'h0, rex[k]}, q);
    end
    sel <= 4'hE;
    wb(MCP_IDX_CH2_DUTY, 1, 8'h11);
    sel <= 4'hF;
    wb(MCP_IDX_CH2_DUTY, 0, 0);
    chk("masked write", 32'hA5, q);
    // Full duty on all channels, so the waveform reads constant high
    for (int c = 0; c < 3; c++) wb(26'(MCP_IDX_CH2_DUTY + 2 * c), 1, 8'hFF);
    repeat (600) @(posedge clk_i);
    for (int a = 0; a < 2; a++)
      for (int m = 0; m < 4; m++)
      begin
        @(posedge clk_i);
        // Gpio drives low with a=0 and floats to the pull-up with a=1
        fs <= a[0]; ns <= !a[0]; cs <= !a[0]; md <= !a[0]; g5 <= a[0]; g10 <= a[0]; g5e <= !a[0]; g10e <= !a[0];
        wb(MCP_IDX_PINCFG, 1, m[1] ? 8'h07 : 8'h00);
        for (int c = 0; c < 3; c++) wb(26'(MCP_IDX_CH2_SEL + 2 * c), 1, {m[0], 7'h0});
        repeat (3) @(posedge clk_i);
        #1;
        for (int c = 0; c < 3; c++)
          chk("pin", m[1] ? (m[0] ? 1 : !a[0]) : a[0], po[c]);
        chk("pin oe", m[1] ? 3'b111 : {!a[0], !a[0], 1'b1}, poe);
        if (!m[1]) chk("gpio in", {a[0], a[0]}, {gi10, gi5});
      end
    foreach (pd[k])
    begin
      wb(26'(MCP_IDX_CH2_SEL + 2 * pc[k]), 1, {7'h0, pv[k]});
      wb(26'(MCP_IDX_CH2_DUTY + 2 * pc[k]), 1, pd[k]);
      edge_up(pc[k]);
      edge_up(pc[k]);
      nh = 0;
      nl = 0;
      while (wv[pc[k]] === 1'b1 && nh < 600)
      begin
        nh++;
        @(posedge clk_i);
      end
      while (wv[pc[k]] === 1'b0 && nl < 600)
      begin
        nl++;
        @(posedge clk_i);
      end
      chk("high steps", (pd[k] + 1) * (pv[k] + 1), nh);
      chk("period", MCP_PERIOD * (pv[k] + 1), nh + nl);
    end
    @(posedge clk_i);
    rst_i <= 1;
    repeat (4) @(posedge clk_i);
    chk("wave in reset", 3'b111, wv);
    rst_i <= 0;
    wb(MCP_IDX_CH4_DUTY, 0, 0);
    chk("duty after reset", 0, q);
    summarize();
  end
endmodule
